// file: channel_enable_scan_rate_regs.sv
// Function
// - Bits 7:4 enable channels in low power
// - Bits 3:0 enable channels 3..0
// - Channel enable register resets to 1Fh
// - Fast bit selects 160 SPS, not continuous
// - Continuous bit scans back to back, wins
// - Continuous scanning uses fixed baseline increment
// - Continuous bit ignored in low power
// - Normal rate code: 80/40/20/10 SPS, reset 1
// - Low-power rate code: 5/2.5/1.25/0.625 SPS
// - Low-power rate register resets to 10h
// - Normal rate register resets to 01h
// - Channel 0 gain six bits, reset 28h
// - Channel 1 gain at 10h, reset 28h
`timescale 1ns/10ps
`default_nettype none
module channel_enable_scan_rate_regs #(
    parameter int unsigned SCAN_FAST_CYC =
        scan_regs_pkg::FAST_PERIOD_NS / scan_regs_pkg::CLK_PERIOD_NS,
    parameter logic [6:0] DEV_ADDR = 7'h2a // Arbitrary value
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n,
    // Device state
    input wire logic config_mode,
    input wire logic lowpower_mode,
    // Converter handshake
    output logic scan_start,
    output logic [3:0] scan_mask,
    input wire logic scan_done,
    output logic fixed_increment,
    // Settings to the button algorithm
    output scan_regs_pkg::scan_cfg_s cfg
);
    import scan_regs_pkg::*;

    typedef enum {SC_HALT, SC_IDLE, SC_BUSY} scan_state_e;

    reg_wr_s wr;
    logic [7:0] rd_addr, rd_data;
    logic [7:0] chan_q, chan_d, nrate_q, nrate_d, lrate_q, lrate_d;
    logic [7:0] ch0_sensitivity_q, ch0_sensitivity_d, ch1_sensitivity_q, ch1_sensitivity_d;
    scan_state_e sc_q, sc_d;
    logic [31:0] cnt_q, cnt_d, period;
    logic start_q, start_d, fixed_q, fixed_d;
    logic [3:0] mask_q, mask_d, want_mask;
    logic cont_eff, tick;

    ////////////////////////////////////////////////////////////////////////
    // Rate decode: shift of the 160 SPS period
    function automatic logic [3:0] rate_shift(input logic lp,
                                              input logic [7:0] nr,
                                              input logic [7:0] lr);
        logic [3:0] s;
        s = 4'h0;
        if (lp) begin
            s = LOWPOWER_SHIFT_BASE + {2'h0, lr[RATE_CODE_LSB +: 2]};
        end else if (nr[FAST_RATE_BIT]) begin
            s = 4'h0;
        end else begin
            s = NORMAL_SHIFT_BASE + {2'h0, nr[RATE_CODE_LSB +: 2]};
        end
        return s;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Serial port
    serial_reg_port #(
        .DEV_ADDR(DEV_ADDR)
    ) u_port (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .sda_oe_n(sda_oe_n),
        .wr(wr),
        .rd_addr(rd_addr),
        .rd_data(rd_data)
    );

    assign sda_out = 1'b0;

    ////////////////////////////////////////////////////////////////////////
    // Register bank, reserved bits stored as written
    always_comb begin
        chan_d = chan_q;
        nrate_d = nrate_q;
        ch0_sensitivity_d = ch0_sensitivity_q;
        lrate_d = lrate_q;
        ch1_sensitivity_d = ch1_sensitivity_q;
        if (wr.en) begin
            case (wr.addr)
                OFS_CHANNEL_POWER_SELECT: chan_d = wr.data;
                OFS_NORMAL_SCAN_RATE: nrate_d = wr.data;
                OFS_CH0_SENSITIVITY: ch0_sensitivity_d = wr.data;
                OFS_LOWPOWER_SCAN_RATE: lrate_d = wr.data;
                OFS_CH1_SENSITIVITY: ch1_sensitivity_d = wr.data;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            chan_q <= RST_CHANNEL_POWER_SELECT;
            nrate_q <= RST_NORMAL_SCAN_RATE;
            ch0_sensitivity_q <= RST_CH0_SENSITIVITY;
            lrate_q <= RST_LOWPOWER_SCAN_RATE;
            ch1_sensitivity_q <= RST_CH1_SENSITIVITY;
        end else begin
            chan_q <= chan_d;
            nrate_q <= nrate_d;
            ch0_sensitivity_q <= ch0_sensitivity_d;
            lrate_q <= lrate_d;
            ch1_sensitivity_q <= ch1_sensitivity_d;
        end
    end

    always_comb begin
        case (rd_addr)
            OFS_CHANNEL_POWER_SELECT: rd_data = chan_q;
            OFS_NORMAL_SCAN_RATE: rd_data = nrate_q;
            OFS_CH0_SENSITIVITY: rd_data = ch0_sensitivity_q;
            OFS_LOWPOWER_SCAN_RATE: rd_data = lrate_q;
            OFS_CH1_SENSITIVITY: rd_data = ch1_sensitivity_q;
            default: rd_data = RST_UNMAPPED_READ;
        endcase
    end

    assign cfg = '{
        ch_lowpower_on: chan_q[LOWPOWER_ON_LSB +: 4],
        ch_active: chan_q[ACTIVE_LSB +: 4],
        normal_fast_rate: nrate_q[FAST_RATE_BIT],
        normal_continuous_scan: nrate_q[CONTINUOUS_BIT],
        normal_rate_code: nrate_q[RATE_CODE_LSB +: 2],
        lowpower_rate_code: lrate_q[RATE_CODE_LSB +: 2],
        ch0_sensitivity_word: ch0_sensitivity_q[SENSITIVITY_LSB +: 6],
        ch1_sensitivity_word: ch1_sensitivity_q[SENSITIVITY_LSB +: 6]
    };

    ////////////////////////////////////////////////////////////////////////
    // Scan scheduler
    assign cont_eff = nrate_q[CONTINUOUS_BIT] & ~lowpower_mode;
    assign period = SCAN_FAST_CYC << rate_shift(lowpower_mode, nrate_q,
                                                 lrate_q);
    assign tick = (cnt_q == 32'h0);
    // Low-power scan needs both enables
    assign want_mask = lowpower_mode ?
        (chan_q[LOWPOWER_ON_LSB +: 4] & chan_q[ACTIVE_LSB +: 4]) :
        chan_q[ACTIVE_LSB +: 4];

    always_comb begin
        sc_d = sc_q;
        cnt_d = tick ? period - 32'h1 : cnt_q - 32'h1;
        start_d = 1'b0;
        mask_d = mask_q;
        fixed_d = fixed_q;
        case (sc_q)
            SC_HALT: begin
                cnt_d = period - 32'h1;
                if (!config_mode) begin
                    sc_d = SC_IDLE;
                end
            end
            SC_IDLE: begin
                if (config_mode) begin
                    sc_d = SC_HALT;
                end else if ((cont_eff || tick) && want_mask != 4'h0) begin
                    start_d = 1'b1;
                    mask_d = want_mask;
                    fixed_d = cont_eff;
                    sc_d = SC_BUSY;
                end
            end
            SC_BUSY: begin
                if (scan_done) begin
                    sc_d = config_mode ? SC_HALT : SC_IDLE;
                end
            end
            default: begin
                sc_d = SC_HALT;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            sc_q <= SC_HALT;
            cnt_q <= 32'h0;
            start_q <= 1'b0;
            mask_q <= 4'h0;
            fixed_q <= 1'b0;
        end else begin
            sc_q <= sc_d;
            cnt_q <= cnt_d;
            start_q <= start_d;
            mask_q <= mask_d;
            fixed_q <= fixed_d;
        end
    end

    assign scan_start = start_q;
    assign scan_mask = mask_q;
    assign fixed_increment = fixed_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    logic first_q;

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            first_q <= 1'b0;
        end else begin
            first_q <= 1'b1;
        end
    end

    sequence s_done_cont;
        sc_q == SC_BUSY && scan_done && cont_eff && !config_mode;
    endsequence

    sequence s_restart;
        ##1 (want_mask != 4'h0 && !config_mode) ##1 scan_start;
    endsequence

    a_reset_values: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !first_q |-> chan_q == 8'h1f && nrate_q == 8'h01 &&
            lrate_q == 8'h10 && ch0_sensitivity_q == 8'h28 && ch1_sensitivity_q == 8'h28)
        else $error("register reset value wrong");

    a_ch1_write: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        wr.en && wr.addr == 8'h10 |=> ch1_sensitivity_q == $past(wr.data))
        else $error("channel 1 gain write lost");

    a_lowpower_mask: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        start_d && lowpower_mode |=>
            scan_mask == ($past(chan_q[7:4]) & $past(chan_q[3:0])))
        else $error("low-power channel mask wrong");

    a_normal_mask: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        start_d && !lowpower_mode |=> scan_mask == $past(chan_q[3:0]))
        else $error("normal channel mask wrong");

    a_cont_back: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        s_done_cont |-> s_restart or
            ##1 (want_mask == 4'h0 || config_mode || !cont_eff))
        else $error("continuous scan not back to back");

    a_fixed_inc: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        start_d |=> fixed_increment == $past(nrate_q[2] & !lowpower_mode))
        else $error("baseline increment choice wrong");

    a_lp_no_cont: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        sc_q == SC_IDLE && lowpower_mode && !tick |=> !scan_start)
        else $error("low-power scan without rate tick");

    a_fast_rate: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !lowpower_mode && nrate_q[3] |-> period == SCAN_FAST_CYC)
        else $error("fast rate period wrong");

    a_normal_rate: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        !lowpower_mode && !nrate_q[3] |->
            period == SCAN_FAST_CYC << (nrate_q[1:0] + 2'h0 + 1))
        else $error("normal rate period wrong");

    a_lowpower_rate: assert property (
        @(posedge clk_sys) disable iff (!resetn)
        lowpower_mode |-> period == SCAN_FAST_CYC << (lrate_q[1:0] + 5))
        else $error("low-power rate period wrong");

endmodule
`default_nettype wire

// file: channel_enable_scan_rate_regs_tb.sv
`timescale 1ns/10ps
`default_nettype none
module channel_enable_scan_rate_regs_tb;
    import scan_regs_pkg::*;

    localparam int FAST = 16;
    localparam logic [6:0] DEV = 7'h2a; // Arbitrary value
    localparam logic [25:0] CFG_RST =
        {4'h1, 4'hf, 1'b0, 1'b0, 2'h1, 2'h0, 6'h28, 6'h28};

    typedef struct {
        logic [7:0] nrate;
        logic [7:0] lrate;
        logic lp;
        int dly;
        int gap;
        logic fixed;
        logic [3:0] mask;
    } row_s;

    row_s rows [12] = '{
        '{8'h00, 8'h10, 1'b0, 1, 32, 1'b0, 4'hf},
        '{8'h01, 8'h10, 1'b0, 1, 64, 1'b0, 4'hf},
        '{8'h02, 8'h10, 1'b0, 1, 128, 1'b0, 4'hf},
        '{8'h03, 8'h10, 1'b0, 1, 256, 1'b0, 4'hf},
        '{8'h0b, 8'h10, 1'b0, 1, 16, 1'b0, 4'hf},
        '{8'h0e, 8'h10, 1'b0, 1, 4, 1'b1, 4'hf},
        '{8'h04, 8'h10, 1'b0, 6, 9, 1'b1, 4'hf},
        '{8'h08, 8'h10, 1'b0, 20, 32, 1'b0, 4'hf},
        '{8'h04, 8'h10, 1'b1, 1, 512, 1'b0, 4'h1},
        '{8'h04, 8'h11, 1'b1, 1, 1024, 1'b0, 4'h1},
        '{8'h04, 8'h12, 1'b1, 1, 2048, 1'b0, 4'h1},
        '{8'h04, 8'h13, 1'b1, 1, 4096, 1'b0, 4'h1}
    };

    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic config_mode = 1'b1;
    logic lowpower_mode = 1'b0;
    logic scan_done = 1'b0;
    logic scl, host_oe_n, dut_oe_n, sda_out, scan_start, fixed_increment;
    logic [3:0] scan_mask;
    scan_cfg_s cfg;
    wire logic sda_line = host_oe_n & (dut_oe_n | sda_out);
    int done_dly = 1;
    int done_cnt = 0;
    int starts = 0;
    int error_cnt = 0;
    int checks_done = 0;

    always #4 clk_sys = ~clk_sys;

    channel_enable_scan_rate_regs #(
        .SCAN_FAST_CYC(FAST),
        .DEV_ADDR(DEV)
    ) dut_u (
        .clk_sys(clk_sys), .resetn(resetn), .scl_in(scl),
        .sda_in(sda_line), .sda_out(sda_out), .sda_oe_n(dut_oe_n),
        .config_mode(config_mode), .lowpower_mode(lowpower_mode),
        .scan_start(scan_start), .scan_mask(scan_mask),
        .scan_done(scan_done), .fixed_increment(fixed_increment),
        .cfg(cfg)
    );

    i2c_host_model #(.DEV_ADDR(DEV)) host_u (
        .clk_sys(clk_sys), .sda_line(sda_line), .scl(scl),
        .sda_oe_n(host_oe_n)
    );

    ////////////////////////////////////////////////////////////////////////
    // Converter: finishes each scan done_dly cycles after its start
    always @(posedge clk_sys) begin
        scan_done <= (scan_start !== 1'b1) && (done_cnt == 1);
        if (scan_start === 1'b1) begin
            starts <= starts + 1;
            done_cnt <= done_dly;
        end else if (done_cnt != 0) begin
            done_cnt <= done_cnt - 1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] seen, exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wait_start(output int n);
        n = 0;
        do begin
            @(posedge clk_sys);
            #1;
            n++;
        end while (scan_start !== 1'b1 && n < 6000);
        if (n >= 6000) begin
            check("scan start timeout", 0, 1);
            give_verdict();
        end
    endtask

    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        logic ok;
        host_u.wr_reg(DEV, ofs, data, ok);
        check("write ack", ok, 1'b1);
    endtask

    task automatic rd(input logic [7:0] ofs, input logic [7:0] exp);
        logic [15:0] d;
        logic ok;
        host_u.rd_reg(ofs, 1'b0, d, ok);
        check("read ack", ok, 1'b1);
        check($sformatf("reg %h", ofs), d[15:8], exp);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int n;
        int snap;
        logic ok;
        logic [15:0] pair;
        repeat (6) @(posedge clk_sys);
        check("oe in reset", dut_oe_n, 1'b1);
        check("cfg in reset", cfg, CFG_RST);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(OFS_CHANNEL_POWER_SELECT, 8'h1f);
        rd(OFS_NORMAL_SCAN_RATE, 8'h01);
        rd(OFS_CH0_SENSITIVITY, 8'h28);
        rd(OFS_LOWPOWER_SCAN_RATE, 8'h10);
        rd(OFS_CH1_SENSITIVITY, 8'h28);
        $display("test reset values done");

        foreach (rows[i]) begin
            @(posedge clk_sys);
            config_mode <= 1'b1;
            lowpower_mode <= rows[i].lp;
            done_dly = rows[i].dly;
            wr(OFS_NORMAL_SCAN_RATE, rows[i].nrate);
            snap = starts;
            wr(OFS_LOWPOWER_SCAN_RATE, rows[i].lrate);
            rd(OFS_NORMAL_SCAN_RATE, rows[i].nrate);
            rd(OFS_LOWPOWER_SCAN_RATE, rows[i].lrate);
            check("starts in config", starts, snap);
            @(posedge clk_sys);
            config_mode <= 1'b0;
            wait_start(n);
            check("scan mask", scan_mask, rows[i].mask);
            check("fixed inc", fixed_increment, rows[i].fixed);
            wait_start(n);
            check("scan gap", n, rows[i].gap);
            $display("test rate row %0d done", i);
        end

        @(posedge clk_sys);
        config_mode <= 1'b1;
        lowpower_mode <= 1'b0;
        done_dly = 1;
        wr(OFS_CHANNEL_POWER_SELECT, 8'h37);
        wr(OFS_CH0_SENSITIVITY, 8'h15);
        wr(OFS_CH1_SENSITIVITY, 8'h3a);
        wr(8'h12, 8'h77);
        rd(OFS_CHANNEL_POWER_SELECT, 8'h37);
        rd(OFS_CH0_SENSITIVITY, 8'h15);
        rd(OFS_CH1_SENSITIVITY, 8'h3a);
        rd(8'h12, 8'h00);
        check("cfg fields", cfg,
              {4'h3, 4'h7, 1'b0, 1'b1, 2'h0, 2'h3, 6'h15, 6'h3a});
        host_u.wr_reg(DEV ^ 7'h01, OFS_CH0_SENSITIVITY, 8'h01, ok);
        check("stray address ack", ok, 1'b0);
        rd(OFS_CH0_SENSITIVITY, 8'h15);
        host_u.rd_reg(OFS_CH0_SENSITIVITY, 1'b1, pair, ok);
        check("burst read ack", ok, 1'b1);
        check("burst read", pair, 16'h1513);
        @(posedge clk_sys);
        config_mode <= 1'b0;
        lowpower_mode <= 1'b1;
        wait_start(n);
        check("lowpower mask", scan_mask, 4'h3);
        check("lowpower fixed", fixed_increment, 1'b0);
        @(posedge clk_sys);
        lowpower_mode <= 1'b0;
        wait_start(n);
        wait_start(n);
        check("normal mask", scan_mask, 4'h7);
        check("continuous gap", n, 4);
        $display("test channel select done");

        @(posedge clk_sys);
        config_mode <= 1'b1;
        repeat (20) @(posedge clk_sys);
        resetn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check("cfg mid reset", cfg, CFG_RST);
        check("mask mid reset", scan_mask, 4'h0);
        resetn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rd(OFS_CHANNEL_POWER_SELECT, 8'h1f);
        $display("test second reset done");
        give_verdict();
    end
endmodule
`default_nettype wire

// file: i2c_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module i2c_host_model #(
    parameter logic [6:0] DEV_ADDR = 7'h2a, // Arbitrary value
    parameter int HALF_CYC = 4
) (
    // Clock
    input wire logic clk_sys,
    // Bus
    input wire logic sda_line,
    output logic scl,
    output logic sda_oe_n
);
    initial begin
        scl = 1'b1;
        sda_oe_n = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic half();
        repeat (HALF_CYC) @(posedge clk_sys);
    endtask

    // Also serves as repeated start
    task automatic start_cond();
        half();
        sda_oe_n <= 1'b1;
        half();
        scl <= 1'b1;
        half();
        sda_oe_n <= 1'b0;
        half();
        scl <= 1'b0;
    endtask

    task automatic stop_cond();
        half();
        sda_oe_n <= 1'b0;
        half();
        scl <= 1'b1;
        half();
        sda_oe_n <= 1'b1;
        half();
    endtask

    // Data set mid low phase, sampled mid high phase
    task automatic bit_xfer(input logic v, output logic s);
        half();
        sda_oe_n <= v;
        half();
        scl <= 1'b1;
        half();
        s = sda_line;
        half();
        scl <= 1'b0;
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(b[i], s);
        end
        bit_xfer(1'b1, s);
        ack = (s === 1'b0);
    endtask

    task automatic recv_byte(input logic last, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, s);
            b[i] = s;
        end
        bit_xfer(last, s);
    endtask

    ////////////////////////////////////////////////////////////////////////
    task automatic wr_reg(input logic [6:0] dev, input logic [7:0] ofs,
                          input logic [7:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({dev, 1'b0}, a0);
        send_byte(ofs, a1);
        send_byte(data, a2);
        stop_cond();
        ok = a0 & a1 & a2;
    endtask

    // Two bytes: host acks the first, so the pointer steps on
    task automatic rd_reg(input logic [7:0] ofs, input logic two,
                          output logic [15:0] data, output logic ok);
        logic a0, a1, a2;
        start_cond();
        send_byte({DEV_ADDR, 1'b0}, a0);
        send_byte(ofs, a1);
        start_cond();
        send_byte({DEV_ADDR, 1'b1}, a2);
        data = 16'h0000;
        recv_byte(!two, data[15:8]);
        if (two) begin
            recv_byte(1'b1, data[7:0]);
        end
        stop_cond();
        ok = a0 & a1 & a2;
    endtask
endmodule
`default_nettype wire

// file: scan_regs_pkg.sv
`default_nettype none
package scan_regs_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register offsets
    localparam logic [7:0] OFS_CHANNEL_POWER_SELECT = 8'h0c;
    localparam logic [7:0] OFS_NORMAL_SCAN_RATE = 8'h0d;
    localparam logic [7:0] OFS_CH0_SENSITIVITY = 8'h0e;
    localparam logic [7:0] OFS_LOWPOWER_SCAN_RATE = 8'h0f;
    localparam logic [7:0] OFS_CH1_SENSITIVITY = 8'h10;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [7:0] RST_CHANNEL_POWER_SELECT = 8'h1f;
    localparam logic [7:0] RST_NORMAL_SCAN_RATE = 8'h01;
    localparam logic [7:0] RST_CH0_SENSITIVITY = 8'h28;
    localparam logic [7:0] RST_LOWPOWER_SCAN_RATE = 8'h10;
    localparam logic [7:0] RST_CH1_SENSITIVITY = 8'h28;
    localparam logic [7:0] RST_UNMAPPED_READ = 8'h00;

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int LOWPOWER_ON_LSB = 4;
    localparam int ACTIVE_LSB = 0;
    localparam int FAST_RATE_BIT = 3;
    localparam int CONTINUOUS_BIT = 2;
    localparam int RATE_CODE_LSB = 0;
    localparam int SENSITIVITY_LSB = 0;

    ////////////////////////////////////////////////////////////////////////
    // Timing: every rate is the 160 SPS period times a power of two
    localparam int unsigned CLK_PERIOD_NS = 8;
    localparam int unsigned FAST_PERIOD_NS = 6250000;
    localparam logic [3:0] NORMAL_SHIFT_BASE = 4'h1;
    localparam logic [3:0] LOWPOWER_SHIFT_BASE = 4'h5;

    ////////////////////////////////////////////////////////////////////////
    // Carriers
    typedef struct packed {
        logic [3:0] ch_lowpower_on;
        logic [3:0] ch_active;
        logic normal_fast_rate;
        logic normal_continuous_scan;
        logic [1:0] normal_rate_code;
        logic [1:0] lowpower_rate_code;
        logic [5:0] ch0_sensitivity_word;
        logic [5:0] ch1_sensitivity_word;
    } scan_cfg_s;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } reg_wr_s;

endpackage
`default_nettype wire

// file: serial_reg_port.sv
`timescale 1ns/10ps
`default_nettype none
module serial_reg_port #(
    parameter logic [6:0] DEV_ADDR = 7'h2a
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Two-wire pins
    input wire logic scl_in,
    input wire logic sda_in,
    output logic sda_oe_n,
    // Register side
    output scan_regs_pkg::reg_wr_s wr,
    output logic [7:0] rd_addr,
    input wire logic [7:0] rd_data
);
    import scan_regs_pkg::*;

    typedef enum {I_IDLE, I_ADDR, I_PTR, I_WDATA, I_ACK, I_RDATA, I_RACK}
        port_state_e;

    port_state_e st_q, st_d, after_q, after_d;
    logic [1:0] scl_sy_q, sda_sy_q;
    logic scl_p_q, sda_p_q;
    logic [3:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, ptr_q, ptr_d;
    logic got_q, got_d, oe_n_q, oe_n_d;
    reg_wr_s wr_q, wr_d;
    logic scl_s, sda_s, rise, fall, start, stop;

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers, edges read only the second stage
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            scl_sy_q <= 2'h3;
            sda_sy_q <= 2'h3;
            scl_p_q <= 1'b1;
            sda_p_q <= 1'b1;
        end else begin
            scl_sy_q <= {scl_sy_q[0], scl_in};
            sda_sy_q <= {sda_sy_q[0], sda_in};
            scl_p_q <= scl_sy_q[1];
            sda_p_q <= sda_sy_q[1];
        end
    end

    assign scl_s = scl_sy_q[1];
    assign sda_s = sda_sy_q[1];
    assign rise = scl_s & ~scl_p_q;
    assign fall = ~scl_s & scl_p_q;
    assign start = scl_s & scl_p_q & sda_p_q & ~sda_s;
    assign stop = scl_s & scl_p_q & ~sda_p_q & sda_s;

    ////////////////////////////////////////////////////////////////////////
    // Byte engine
    always_comb begin
        st_d = st_q;
        after_d = after_q;
        bit_d = bit_q;
        sh_d = sh_q;
        ptr_d = ptr_q;
        got_d = got_q;
        oe_n_d = oe_n_q;
        wr_d = '0;
        if (start) begin
            st_d = I_ADDR;
            bit_d = 4'h0;
            got_d = 1'b0;
            oe_n_d = 1'b1;
        end else if (stop) begin
            st_d = I_IDLE;
            oe_n_d = 1'b1;
        end else begin
            case (st_q)
                I_ADDR, I_PTR, I_WDATA: begin
                    if (rise && !got_q) begin
                        sh_d = {sh_q[6:0], sda_s};
                        bit_d = bit_q + 4'h1;
                        got_d = (bit_q == 4'h7);
                    end else if (fall && got_q) begin
                        got_d = 1'b0;
                        bit_d = 4'h0;
                        oe_n_d = 1'b0;
                        st_d = I_ACK;
                        if (st_q == I_ADDR) begin
                            after_d = sh_q[0] ? I_RDATA : I_PTR;
                            if (sh_q[7:1] != DEV_ADDR) begin
                                oe_n_d = 1'b1;
                                st_d = I_IDLE;
                            end
                        end else if (st_q == I_PTR) begin
                            ptr_d = sh_q;
                            after_d = I_WDATA;
                        end else begin
                            wr_d = '{en: 1'b1, addr: ptr_q, data: sh_q};
                            ptr_d = ptr_q + 8'h01;
                            after_d = I_WDATA;
                        end
                    end
                end
                I_ACK: begin
                    if (fall) begin
                        oe_n_d = 1'b1;
                        st_d = after_q;
                        if (after_q == I_RDATA) begin
                            sh_d = rd_data;
                            oe_n_d = rd_data[7];
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                I_RDATA: begin
                    if (fall) begin
                        bit_d = bit_q + 4'h1;
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_n_d = sh_q[6];
                        if (bit_q == 4'h7) begin
                            oe_n_d = 1'b1;
                            bit_d = 4'h0;
                            st_d = I_RACK;
                        end
                    end
                end
                I_RACK: begin
                    if (rise) begin
                        got_d = ~sda_s;
                    end else if (fall) begin
                        st_d = got_q ? I_RDATA : I_IDLE;
                        got_d = 1'b0;
                        if (got_q) begin
                            sh_d = rd_data;
                            oe_n_d = rd_data[7];
                            ptr_d = ptr_q + 8'h01;
                        end
                    end
                end
                default: begin
                    oe_n_d = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            st_q <= I_IDLE;
            after_q <= I_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h00;
            ptr_q <= 8'h00;
            got_q <= 1'b0;
            oe_n_q <= 1'b1;
            wr_q <= '0;
        end else begin
            st_q <= st_d;
            after_q <= after_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            ptr_q <= ptr_d;
            got_q <= got_d;
            oe_n_q <= oe_n_d;
            wr_q <= wr_d;
        end
    end

    assign sda_oe_n = oe_n_q;
    assign wr = wr_q;
    assign rd_addr = ptr_q;

endmodule
`default_nettype wire
